/* File: gain_pulse_defines.vh */
// register map, field layout, reset values and bus codes for the gain and pulse-output block
`ifndef GAIN_PULSE_DEFINES_VH
`define GAIN_PULSE_DEFINES_VH

// ****************************************
// register indices, byte address is index times four
// ****************************************
`define IDX_PHASE_INCLUDE 16'he60e
`define IDX_CHANNEL_GAIN_SELECT 16'he60f
`define IDX_PULSE_OUTPUT_MODE 16'he610
`define AXI_ADDR_W 18

// ****************************************
// channel_gain_select fields
// ****************************************
`define GAIN_PH_CUR_LSB 0
`define GAIN_NEU_CUR_LSB 3
`define GAIN_PH_VOLT_LSB 6
`define GAIN_USED_MASK 16'h01ff
`define GAIN_RESET 16'h0000
`define GAIN_CODE_MAX 3'h4
`define GAIN_CODE_DEFAULT 3'h0

// ****************************************
// pulse_output_mode fields
// ****************************************
`define PMODE_SEL_ONE_LSB 0
`define PMODE_SEL_TWO_LSB 3
`define PMODE_SEL_THREE_LSB 6
`define PMODE_DIS_LSB 9
`define PMODE_USED_MASK 16'h0fff
`define PMODE_RESET 16'h0e88
`define QTY_CODE_MAX 3'h4

// ****************************************
// phase include fields
// ****************************************
`define PINC_USED_MASK 16'h01ff
`define PINC_RESET 16'h01ff

// ****************************************
// bus answer codes
// ****************************************
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: pulse_route.v */
// one pulse output path: quantity decode, phase include and pin gating
`timescale 1ns/1ps
`include "gain_pulse_defines.vh"

module pulse_route (
  input wire aclk,
  input wire aresetn,
  input wire [2:0] quantity_code,
  input wire [2:0] phase_include_in,
  input wire disable_in,
  input wire converter_pulse,
  output reg [4:0] quantity_onehot_r,
  output reg [2:0] phase_include_r,
  output reg converter_enable_r,
  output reg pin_r
);

  wire code_valid;

  assign code_valid = (quantity_code <= `QTY_CODE_MAX);

  // ****************************************
  // registered decode
  // ****************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      quantity_onehot_r <= 5'h01;
      phase_include_r <= 3'h7;
      converter_enable_r <= 1'b0;
      pin_r <= 1'b0;
    end else begin
      // reserved codes select nothing
      quantity_onehot_r <= code_valid ? (5'h01 << quantity_code) : 5'h00;
      // phase a, b, c from low bit upward
      phase_include_r <= phase_include_in;
      // converter keeps running whatever the disable bit
      converter_enable_r <= code_valid;
      // pin follows pulses only when enabled and code valid
      pin_r <= converter_pulse & code_valid & ~disable_in;
    end
  end

endmodule

/* File: gain_and_pulse_output_select.v */
// gain selection and pulse output mode registers behind an axi4-lite slave
//
// Contract
// - phase current gain bits 2:0, codes 0-4
// - reserved phase current codes act as 000
// - neutral current gain bits 5:3, same mapping
// - reserved neutral current codes act as 000
// - phase voltage gain bits 8:6, same mapping
// - reserved phase voltage codes act as 000
// - gain bits 15:9 reserved, zero, no effect
// - pulse one quantity bits 2:0, reset 000
// - reserved pulse one quantity gives no pulses
// - pulse two quantity bits 5:3, reset 001
// - reserved pulse two quantity gives no pulses
// - pulse three quantity bits 8:6, reset 010
// - reserved pulse three quantity gives no pulses
// - bit 9 disables pin one, converter runs
// - bit 9 clear drives pin one pulses
// - three-bit phase include per output, reset ones
// - bit 10 disables pin two, converter runs
// - bit 11 disables pin three, converter runs
`timescale 1ns/1ps
`include "gain_pulse_defines.vh"

module gain_and_pulse_output_select (
  input wire aclk,
  input wire aresetn,
  input wire [17:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [17:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [2:0] converter_pulse,
  output reg [2:0] phase_current_gain,
  output reg [2:0] neutral_current_gain,
  output reg [2:0] phase_voltage_gain,
  output reg [4:0] phase_current_factor,
  output reg [4:0] neutral_current_factor,
  output reg [4:0] phase_voltage_factor,
  output wire [14:0] quantity_onehot,
  output wire [8:0] phase_include_sel,
  output wire [2:0] converter_enable,
  output wire pulse_output_one,
  output wire pulse_output_two,
  output wire pulse_output_three
);

  // ****************************************
  // register storage
  // ****************************************
  reg [15:0] gain_r;
  reg [15:0] pmode_r;
  reg [15:0] pinc_r;

  // ****************************************
  // write channel state
  // ****************************************
  reg aw_got_r;
  reg w_got_r;
  reg [15:0] aw_idx_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  reg aw_got_nxt;
  reg w_got_nxt;
  reg bvalid_nxt;
  wire aw_take;
  wire w_take;
  wire wr_fire;
  wire wr_hit_gain;
  wire wr_hit_pmode;
  wire wr_hit_pinc;
  wire wr_hit;

  // ****************************************
  // read channel state
  // ****************************************
  wire ar_take;
  wire [15:0] ar_idx;
  reg [31:0] rd_word;
  reg rd_hit;

  wire [2:0] pin_vec;

  // ****************************************
  // gain decode helpers
  // ****************************************
  function [2:0] eff_code;
    input [2:0] code;
    begin
      if (code > `GAIN_CODE_MAX) begin
        eff_code = `GAIN_CODE_DEFAULT;
      end else begin
        eff_code = code;
      end
    end
  endfunction

  function [4:0] factor_of;
    input [2:0] code;
    begin
      factor_of = 5'h01 << eff_code(code);
    end
  endfunction

  function [15:0] merge16;
    input [15:0] old;
    input [31:0] data;
    input [3:0] strb;
    input [15:0] mask;
    reg [15:0] v;
    begin
      v = old;
      if (strb[0]) begin
        v[7:0] = data[7:0];
      end
      if (strb[1]) begin
        v[15:8] = data[15:8];
      end
      merge16 = v & mask;
    end
  endfunction

  // ****************************************
  // write address and data capture, either order
  // ****************************************
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign wr_fire = aw_got_r & w_got_r & ~s_axi_bvalid;
  assign wr_hit_gain = (aw_idx_r == `IDX_CHANNEL_GAIN_SELECT);
  assign wr_hit_pmode = (aw_idx_r == `IDX_PULSE_OUTPUT_MODE);
  assign wr_hit_pinc = (aw_idx_r == `IDX_PHASE_INCLUDE);
  assign wr_hit = wr_hit_gain | wr_hit_pmode | wr_hit_pinc;

  always @* begin
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    bvalid_nxt = s_axi_bvalid;
    if (aw_take) begin
      aw_got_nxt = 1'b1;
    end
    if (w_take) begin
      w_got_nxt = 1'b1;
    end
    if (wr_fire) begin
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bvalid_nxt = 1'b1;
    end
    if (s_axi_bvalid & s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_idx_r <= 16'h0000;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      s_axi_bvalid <= bvalid_nxt;
      s_axi_awready <= ~aw_got_nxt & ~bvalid_nxt;
      s_axi_wready <= ~w_got_nxt & ~bvalid_nxt;
      if (aw_take) begin
        aw_idx_r <= s_axi_awaddr[17:2];
      end
      if (w_take) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      // field defaults
      gain_r <= `GAIN_RESET;
      pmode_r <= `PMODE_RESET;
      pinc_r <= `PINC_RESET;
    end else if (wr_fire) begin
      if (wr_hit_gain) begin
        // reserved gain bits never stored
        gain_r <= merge16(gain_r, wdata_r, wstrb_r, `GAIN_USED_MASK);
      end
      if (wr_hit_pmode) begin
        pmode_r <= merge16(pmode_r, wdata_r, wstrb_r, `PMODE_USED_MASK);
      end
      if (wr_hit_pinc) begin
        pinc_r <= merge16(pinc_r, wdata_r, wstrb_r, `PINC_USED_MASK);
      end
    end
  end

  // ****************************************
  // read channel
  // ****************************************
  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign ar_idx = s_axi_araddr[17:2];

  always @* begin
    rd_word = 32'h00000000;
    rd_hit = 1'b1;
    // stored fields, reserved bits zero
    case (ar_idx)
      `IDX_CHANNEL_GAIN_SELECT: begin
        rd_word = {16'h0000, gain_r};
      end
      `IDX_PULSE_OUTPUT_MODE: begin
        rd_word = {16'h0000, pmode_r};
      end
      `IDX_PHASE_INCLUDE: begin
        rd_word = {16'h0000, pinc_r};
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      if (ar_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ****************************************
  // gain datapath outputs
  // ****************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      phase_current_gain <= 3'h0;
      neutral_current_gain <= 3'h0;
      phase_voltage_gain <= 3'h0;
      phase_current_factor <= 5'h01;
      neutral_current_factor <= 5'h01;
      phase_voltage_factor <= 5'h01;
    end else begin
      // codes 0-4 give gain 1..16, others as 000
      phase_current_gain <= eff_code(gain_r[`GAIN_PH_CUR_LSB +: 3]);
      phase_current_factor <= factor_of(gain_r[`GAIN_PH_CUR_LSB +: 3]);
      // neutral channel same mapping
      neutral_current_gain <= eff_code(gain_r[`GAIN_NEU_CUR_LSB +: 3]);
      neutral_current_factor <= factor_of(gain_r[`GAIN_NEU_CUR_LSB +: 3]);
      // voltage channel same mapping
      phase_voltage_gain <= eff_code(gain_r[`GAIN_PH_VOLT_LSB +: 3]);
      phase_voltage_factor <= factor_of(gain_r[`GAIN_PH_VOLT_LSB +: 3]);
    end
  end

  // ****************************************
  // pulse output paths
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : chan
      // per output quantity, include and disable
      pulse_route u_route (
        .aclk(aclk),
        .aresetn(aresetn),
        .quantity_code(pmode_r[3*g +: 3]),
        .phase_include_in(pinc_r[3*g +: 3]),
        .disable_in(pmode_r[`PMODE_DIS_LSB + g]),
        .converter_pulse(converter_pulse[g]),
        .quantity_onehot_r(quantity_onehot[5*g +: 5]),
        .phase_include_r(phase_include_sel[3*g +: 3]),
        .converter_enable_r(converter_enable[g]),
        .pin_r(pin_vec[g])
      );
    end
  endgenerate

  assign pulse_output_one = pin_vec[0];
  assign pulse_output_two = pin_vec[1];
  assign pulse_output_three = pin_vec[2];

endmodule

/* File: gain_pulse_checker.sv */
// assertions on the gain and pulse-output block ports
`timescale 1ns/1ps
module gain_pulse_checker (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [2:0] converter_pulse,
  input wire [2:0] phase_current_gain,
  input wire [2:0] neutral_current_gain,
  input wire [2:0] phase_voltage_gain,
  input wire [4:0] phase_current_factor,
  input wire [14:0] quantity_onehot,
  input wire [2:0] converter_enable,
  input wire pulse_output_one,
  input wire pulse_output_two
);
  // ********
  // properties
  // ********
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence rd_held;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read answer not one cycle after address");
  a_read_stands: assert property (rd_held |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_write_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped before taken");
  a_gain_range: assert property (phase_current_gain <= 3'h4 && neutral_current_gain <= 3'h4
    && phase_voltage_gain <= 3'h4) else $error("effective gain code out of range");
  a_factor_map: assert property (phase_current_factor == 5'h01 << phase_current_gain)
    else $error("gain factor does not match code");
  a_enable_match: assert property ($past(aresetn) |-> converter_enable[0] == |quantity_onehot[4:0])
    else $error("converter enable differs from quantity decode");
  a_pin_one_cause: assert property (pulse_output_one |-> $past(converter_pulse[0])
    && quantity_onehot[4:0] != 5'h00) else $error("pin one pulse without cause");
  a_pin_two_cause: assert property (pulse_output_two |-> $past(converter_pulse[1])
    && quantity_onehot[9:5] != 5'h00) else $error("pin two pulse without cause");
endmodule

bind gain_and_pulse_output_select gain_pulse_checker u_chk (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_bvalid, .s_axi_bready, .converter_pulse,
  .phase_current_gain, .neutral_current_gain, .phase_voltage_gain, .phase_current_factor,
  .quantity_onehot, .converter_enable, .pulse_output_one, .pulse_output_two);

/* File: tb.sv */
// self-checking bench for the gain and pulse-output block
`timescale 1ns/1ps
`include "gain_pulse_defines.vh"
module tb;
  logic aclk = 0;
  logic aresetn = 0;
  logic [17:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [2:0] converter_pulse = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [2:0] phase_current_gain, neutral_current_gain, phase_voltage_gain, converter_enable;
  logic [4:0] phase_current_factor, neutral_current_factor, phase_voltage_factor;
  logic [14:0] quantity_onehot;
  logic [8:0] phase_include_sel;
  logic pulse_output_one, pulse_output_two, pulse_output_three;
  int failures = 0;
  int samples_checked = 0;
  localparam [17:0] a_inc = {`IDX_PHASE_INCLUDE, 2'b00};
  localparam [17:0] a_gain = {`IDX_CHANNEL_GAIN_SELECT, 2'b00};
  localparam [17:0] a_mode = {`IDX_PULSE_OUTPUT_MODE, 2'b00};

  always #25 aclk = ~aclk;

  gain_and_pulse_output_select DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .converter_pulse, .phase_current_gain, .neutral_current_gain,
    .phase_voltage_gain, .phase_current_factor, .neutral_current_factor, .phase_voltage_factor,
    .quantity_onehot, .phase_include_sel, .converter_enable, .pulse_output_one, .pulse_output_two,
    .pulse_output_three);

  // ********
  // bus and compare tasks
  // ********
  task chk(input [31:0] seen, input [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task wr(input [17:0] a, input [31:0] d, input [1:0] er);
    bit aw, w;
    aw = 0;
    w = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw = 1;
        s_axi_awvalid <= 0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w = 1;
        s_axi_wvalid <= 0;
      end
    end
    s_axi_bready <= 1;
    do @(posedge aclk); while (!s_axi_bvalid);
    chk(s_axi_bresp, er);
    s_axi_bready <= 0;
  endtask

  task rd(input [17:0] a, input [31:0] exp, input [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    s_axi_rready <= 1;
    do @(posedge aclk); while (!s_axi_rvalid);
    chk(s_axi_rdata, exp);
    chk(s_axi_rresp, er);
    s_axi_rready <= 0;
  endtask

  task settle;
    repeat (2) @(posedge aclk);
  endtask

  task close_out;
    $display("compares %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ********
  // tests
  // ********
  initial begin
    int e;
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    rd(a_gain, 0, 0);
    rd(a_mode, 32'h0e88, 0);
    rd(a_inc, 32'h01ff, 0);
    chk(phase_include_sel, 9'h1ff);
    chk(quantity_onehot, 15'h1041);
    chk({pulse_output_three, pulse_output_two, pulse_output_one}, 0);
    $display("test reset done");
    for (int c = 0; c < 8; c++) begin
      e = (c <= 4) ? c : 0;
      wr(a_gain, 32'hffff_fe00 | (c * 32'h49), 0);
      rd(a_gain, c * 32'h49, 0);
      settle;
      chk(phase_current_gain, e);
      chk(neutral_current_gain, e);
      chk(phase_voltage_gain, e);
      chk(phase_voltage_factor, 1 << e);
      chk(phase_current_factor, 1 << e);
      chk(neutral_current_factor, 1 << e);
    end
    s_axi_wstrb <= 4'h1;
    wr(a_gain, 0, 0);
    rd(a_gain, 32'h100, 0);
    s_axi_wstrb <= 4'hf;
    wr(a_gain, 32'h0111, 0);
    settle;
    chk(phase_current_gain, 1);
    chk(neutral_current_gain, 2);
    chk(phase_voltage_gain, 4);
    chk(neutral_current_factor, 32'h4);
    chk(phase_voltage_factor, 32'h10);
    $display("test gain done");
    converter_pulse <= 3'h7;
    for (int c = 0; c < 8; c++) begin
      wr(a_mode, c * 32'h49, 0);
      settle;
      chk(quantity_onehot, (c <= 4) ? {3{5'h01 << c}} : 0);
      chk(converter_enable, (c <= 4) ? 7 : 0);
      chk({pulse_output_three, pulse_output_two, pulse_output_one}, (c <= 4) ? 7 : 0);
    end
    for (int i = 0; i < 3; i++) begin
      wr(a_mode, 32'h200 << i, 0);
      settle;
      chk({pulse_output_three, pulse_output_two, pulse_output_one}, 7 & ~(1 << i));
      chk(converter_enable, 7);
    end
    converter_pulse <= 3'h0;
    settle;
    chk({pulse_output_three, pulse_output_two, pulse_output_one}, 0);
    $display("test pulse done");
    wr(a_inc, 32'hffff_f0a5, 0);
    rd(a_inc, 32'h00a5, 0);
    settle;
    chk(phase_include_sel, 9'h0a5);
    wr(18'h00000, 32'h1, 2);
    rd(18'h00004, 0, 2);
    $display("test include and unmapped done");
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    rd(a_gain, 0, 0);
    rd(a_mode, 32'h0e88, 0);
    rd(a_inc, 32'h01ff, 0);
    chk(quantity_onehot, 15'h1041);
    $display("test second reset done");
    close_out;
  end

  initial begin
    #100000;
    failures++;
    close_out;
  end
endmodule
